// ==== verilog/gmii_regs.svh ====
`ifndef GMII_REGS_SVH
`define GMII_REGS_SVH

// Local clock and link timing
`define GMII_MCLK_NS          10
`define GMII_NOM_PERIOD_NS    80
`define GMII_MAX_STRETCH_NOM  2
`define GMII_HALF_CYC         ((`GMII_NOM_PERIOD_NS / 2 + `GMII_MCLK_NS - 1) / `GMII_MCLK_NS)
`define GMII_MAX_PHASE_CYC    ((`GMII_MAX_STRETCH_NOM * `GMII_NOM_PERIOD_NS) / `GMII_MCLK_NS)
`define GMII_GTX_PERIOD_NS    80
`define GMII_GTX_HALF_CYC     ((`GMII_GTX_PERIOD_NS / 2) / `GMII_MCLK_NS)

// Octet values carried with the error line during carrier extension, and the idle octet
`define GMII_EXT_CODE         8'h0f
`define GMII_EXTERR_CODE      8'h1f
`define GMII_IDLE_DATA        8'h00

`endif

// ==== verilog/gmii_pkg.sv ====
package gmii_pkg;

  typedef enum logic [2:0] {
    SYM_IDLE   = 3'h0,
    SYM_DATA   = 3'h1,
    SYM_EOP    = 3'h3,
    SYM_EXTEND = 3'h2,
    SYM_ERROR  = 3'h6,
    SYM_EXTERR = 3'h7
  } sym_t;

  typedef struct packed {
    logic       gtxS1;
    logic       gtxS2;
    logic       gtxS3;
    logic       txEnS1;
    logic       txEnS2;
    logic       txErS1;
    logic       txErS2;
    logic [7:0] txdS1;
    logic [7:0] txdS2;
    logic       recS1;
    logic       recS2;
    logic       rxClk;
    logic [7:0] phaseCnt;
    logic       rxDv;
    logic       rxEr;
    logic [7:0] rxd;
    logic       rxAfter;
    logic       txPrevEn;
    logic       txInExt;
    sym_t       txSym;
    logic [7:0] txData;
    logic       txStrobe;
    sym_t       loopSym;
    logic [7:0] loopData;
    logic       crs;
    logic       col;
  } phy_state_t;

  typedef struct packed {
    logic       gtxClk;
    logic [7:0] gtxCnt;
    logic       txEn;
    logic       txEr;
    logic [7:0] txd;
    logic       txAfter;
    logic       rxClkS1;
    logic       rxClkS2;
    logic       rxClkS3;
    logic       dvS1;
    logic       dvS2;
    logic       erS1;
    logic       erS2;
    logic [7:0] rxdS1;
    logic [7:0] rxdS2;
    logic       prevDv;
    logic       inExt;
    logic       frameErr;
    logic       rxValid;
    logic [7:0] rxData;
    logic       rxExtend;
    logic       rxEnd;
    logic       crsS1;
    logic       crsS2;
    logic       colS1;
    logic       colS2;
  } rs_state_t;

endpackage : gmii_pkg

// ==== verilog/gmii_if.sv ====
interface gmii_if;
  logic       gtxClk;
  logic       txEn;
  logic       txEr;
  logic [7:0] txd;
  logic       rxClk;
  logic       rxDv;
  logic       rxEr;
  logic [7:0] rxd;
  logic       crs;
  logic       col;

  modport rs (
    output gtxClk,
    output txEn,
    output txEr,
    output txd,
    input  rxClk,
    input  rxDv,
    input  rxEr,
    input  rxd,
    input  crs,
    input  col
  );

  modport phy (
    input  gtxClk,
    input  txEn,
    input  txEr,
    input  txd,
    output rxClk,
    output rxDv,
    output rxEr,
    output rxd,
    output crs,
    output col
  );
endinterface : gmii_if

// ==== verilog/gmii_phy_end.sv ====
// Summary of operation
// - RS flags frame error on dv with er
// - RS flags frame error on extend error
// - RS may assert er within frame
// - RS may signal extend error in extension
// - Clock phases never shorter than minimum
// - Clock gap at most two nominal periods
// - Transmit enable spans exactly the frame
// - Transmit lines change on transmit clock
// - Idle transmit data lines are ignored
// - Extension only directly after a frame
// - Error within frame sends invalid code
// - Enable drop with error sends delimiter
// - Transmit error line accepted, always driven
// - Receive lines change on receive clock
// - Data valid spans exactly received frame
// - No loopback unless loopback selected
// - Receive error flags detected stream errors
// - RS reports extension on error without dv
// - Carrier sense while either side busy
// - Carrier sense held through collision
// - Repeater sense follows receive only
// - Collision held while collision persists
`include "gmii_regs.svh"

module gmii_phy_end (
  input  wire logic         mclk,
  input  wire logic         reset,
  gmii_if.phy               link,
  input  wire logic         recClk,
  input  wire logic         sigLost,
  input  wire logic         loopbackEn,
  input  wire logic         repeaterMode,
  input  wire gmii_pkg::sym_t medRxSym,
  input  wire logic [7:0]   medRxData,
  output logic              medRxTake,
  output gmii_pkg::sym_t    medTxSym,
  output logic [7:0]        medTxData,
  output logic              medTxStrobe
);

  gmii_pkg::phy_state_t st_q;
  gmii_pkg::phy_state_t st_d;

  logic           gtxRise;
  logic           toggle;
  logic           rxRise;
  logic [7:0]     phaseNext;
  logic           minMet;
  logic           maxHit;
  gmii_pkg::sym_t rxSrc;
  logic [7:0]     rxSrcData;
  logic           txBusy;
  logic           rxBusy;

  always_comb begin
    st_d = st_q;

    // Pin inputs pass two flops before use
    st_d.gtxS1  = link.gtxClk;
    st_d.gtxS2  = st_q.gtxS1;
    st_d.gtxS3  = st_q.gtxS2;
    st_d.txEnS1 = link.txEn;
    st_d.txEnS2 = st_q.txEnS1;
    st_d.txErS1 = link.txEr;
    st_d.txErS2 = st_q.txErS1;
    st_d.txdS1  = link.txd;
    st_d.txdS2  = st_q.txdS1;
    st_d.recS1  = recClk;
    st_d.recS2  = st_q.recS1;

    gtxRise = st_q.gtxS2 & ~st_q.gtxS3;

    // Receive clock generation; one counter bounds both phases in any source
    phaseNext = st_q.phaseCnt + 8'h01;
    minMet    = phaseNext >= 8'(`GMII_HALF_CYC);
    maxHit    = phaseNext >= 8'(`GMII_MAX_PHASE_CYC);
    if (sigLost) begin
      toggle = minMet;
    end else begin
      toggle = (minMet & (st_q.recS2 != st_q.rxClk)) | maxHit;
    end
    rxRise = toggle & ~st_q.rxClk;
    if (toggle) begin
      st_d.rxClk    = ~st_q.rxClk;
      st_d.phaseCnt = 8'h00;
    end else begin
      st_d.phaseCnt = phaseNext;
    end

    if (loopbackEn) begin
      rxSrc     = st_q.loopSym;
      rxSrcData = st_q.loopData;
    end else begin
      rxSrc     = medRxSym;
      rxSrcData = medRxData;
    end
    medRxTake = rxRise & ~loopbackEn;

    // receive lines move only on rising edge
    if (rxRise) begin
      case (rxSrc)
        gmii_pkg::SYM_DATA: begin
          st_d.rxDv    = 1'b1;
          st_d.rxEr    = 1'b0;
          st_d.rxd     = rxSrcData;
          st_d.rxAfter = 1'b1;
        end
        gmii_pkg::SYM_ERROR: begin
          st_d.rxDv    = 1'b1;
          st_d.rxEr    = 1'b1;
          st_d.rxd     = rxSrcData;
          st_d.rxAfter = 1'b1;
        end
        gmii_pkg::SYM_EOP,
        gmii_pkg::SYM_EXTEND,
        gmii_pkg::SYM_EXTERR: begin
          st_d.rxDv    = 1'b0;
          st_d.rxEr    = st_q.rxAfter;
          st_d.rxAfter = st_q.rxAfter;
          if (!st_q.rxAfter) begin
            st_d.rxd = `GMII_IDLE_DATA;
          end else if (rxSrc == gmii_pkg::SYM_EXTERR) begin
            st_d.rxd = `GMII_EXTERR_CODE;
          end else begin
            st_d.rxd = `GMII_EXT_CODE;
          end
        end
        default: begin
          st_d.rxDv    = 1'b0;
          st_d.rxEr    = 1'b0;
          st_d.rxd     = `GMII_IDLE_DATA;
          st_d.rxAfter = 1'b0;
        end
      endcase
    end

    // Transmit decode, once per transmit clock rising edge
    st_d.txStrobe = gtxRise;
    if (gtxRise) begin
      st_d.txPrevEn = st_q.txEnS2;
      st_d.txData   = st_q.txdS2;
      case ({st_q.txEnS2, st_q.txErS2})
        2'b10: begin
          st_d.txSym = gmii_pkg::SYM_DATA;
        end
        2'b11: begin
          st_d.txSym = gmii_pkg::SYM_ERROR;
        end
        2'b01: begin
          if (st_q.txPrevEn) begin
            st_d.txSym = gmii_pkg::SYM_EOP;
          end else if (st_q.txInExt) begin
            st_d.txSym = (st_q.txdS2 == `GMII_EXTERR_CODE) ? gmii_pkg::SYM_EXTERR : gmii_pkg::SYM_EXTEND;
          end else begin
            st_d.txSym  = gmii_pkg::SYM_IDLE;
            st_d.txData = `GMII_IDLE_DATA;
          end
        end
        default: begin
          st_d.txSym  = gmii_pkg::SYM_IDLE;
          st_d.txData = `GMII_IDLE_DATA;
        end
      endcase
      st_d.txInExt = (st_d.txSym == gmii_pkg::SYM_EOP) || (st_d.txSym == gmii_pkg::SYM_EXTEND)
                     || (st_d.txSym == gmii_pkg::SYM_EXTERR);
      st_d.loopSym  = st_d.txSym;
      st_d.loopData = st_d.txData;
    end

    // Carrier sense and collision; registered so the pins never glitch
    txBusy = st_q.txSym != gmii_pkg::SYM_IDLE;
    rxBusy = loopbackEn ? (st_q.loopSym != gmii_pkg::SYM_IDLE) : (medRxSym != gmii_pkg::SYM_IDLE);
    if (repeaterMode) begin
      st_d.crs = rxBusy;
    end else begin
      st_d.crs = txBusy | rxBusy;
    end
    st_d.col = txBusy & rxBusy & ~loopbackEn;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign link.rxClk  = st_q.rxClk;
  assign link.rxDv   = st_q.rxDv;
  assign link.rxEr   = st_q.rxEr;
  assign link.rxd    = st_q.rxd;
  assign link.crs    = st_q.crs;
  assign link.col    = st_q.col;
  assign medTxSym    = st_q.txSym;
  assign medTxData   = st_q.txData;
  assign medTxStrobe = st_q.txStrobe;

endmodule : gmii_phy_end

// ==== verilog/gmii_rs_end.sv ====
`include "gmii_regs.svh"

module gmii_rs_end (
  input  wire logic       mclk,
  input  wire logic       reset,
  gmii_if.rs              link,
  input  wire logic       macTxEn,
  input  wire logic       macTxErr,
  input  wire logic [7:0] macTxData,
  input  wire logic       macTxExtend,
  input  wire logic       macTxExtErr,
  output logic            macTxTake,
  output logic            macRxValid,
  output logic [7:0]      macRxData,
  output logic            macRxFrameErr,
  output logic            macRxExtend,
  output logic            macRxEnd,
  output logic            macCrs,
  output logic            macCol
);

  gmii_pkg::rs_state_t st_q;
  gmii_pkg::rs_state_t st_d;

  logic       toggle;
  logic       gtxRise;
  logic [7:0] cntNext;
  logic       rxRise;
  logic       extNow;
  logic       extAllowed;

  always_comb begin
    st_d = st_q;

    // Transmit clock from a divider of the local clock
    cntNext = st_q.gtxCnt + 8'h01;
    toggle  = cntNext >= 8'(`GMII_GTX_HALF_CYC);
    gtxRise = toggle & ~st_q.gtxClk;
    if (toggle) begin
      st_d.gtxClk = ~st_q.gtxClk;
      st_d.gtxCnt = 8'h00;
    end else begin
      st_d.gtxCnt = cntNext;
    end
    macTxTake = gtxRise;

    // transmit lines move with clock rise
    if (gtxRise) begin
      st_d.txEn   = macTxEn;
      extAllowed  = st_q.txEn | st_q.txAfter;
      if (macTxEn) begin
        st_d.txEr = macTxErr;
        st_d.txd  = macTxData;
      end else if (macTxExtend && extAllowed) begin
        st_d.txEr = 1'b1;
        st_d.txd  = macTxExtErr ? `GMII_EXTERR_CODE : `GMII_EXT_CODE;
      end else begin
        st_d.txEr = 1'b0;
        st_d.txd  = `GMII_IDLE_DATA;
      end
      st_d.txAfter = ~macTxEn & st_d.txEr;
    end else begin
      extAllowed = 1'b0;
    end

    // Link inputs pass two flops before use
    st_d.rxClkS1 = link.rxClk;
    st_d.rxClkS2 = st_q.rxClkS1;
    st_d.rxClkS3 = st_q.rxClkS2;
    st_d.dvS1    = link.rxDv;
    st_d.dvS2    = st_q.dvS1;
    st_d.erS1    = link.rxEr;
    st_d.erS2    = st_q.erS1;
    st_d.rxdS1   = link.rxd;
    st_d.rxdS2   = st_q.rxdS1;
    st_d.crsS1   = link.crs;
    st_d.crsS2   = st_q.crsS1;
    st_d.colS1   = link.col;
    st_d.colS2   = st_q.colS1;

    rxRise        = st_q.rxClkS2 & ~st_q.rxClkS3;
    st_d.rxValid  = 1'b0;
    st_d.rxExtend = 1'b0;
    st_d.rxEnd    = 1'b0;
    extNow        = 1'b0;
    if (rxRise) begin
      extNow        = ~st_q.dvS2 & st_q.erS2 & (st_q.prevDv | st_q.inExt);
      st_d.rxValid  = st_q.dvS2;
      st_d.rxData   = st_q.rxdS2;
      st_d.rxEnd    = st_q.prevDv & ~st_q.dvS2;
      st_d.rxExtend = extNow;
      st_d.inExt    = extNow;
      st_d.prevDv   = st_q.dvS2;
      // New frame clears the flag; a same-cycle error still sets it
      if (st_q.dvS2 && !st_q.prevDv) begin
        st_d.frameErr = 1'b0;
      end
      if (st_q.dvS2 && st_q.erS2) begin
        st_d.frameErr = 1'b1;
      end
      if (extNow && st_q.rxdS2 == `GMII_EXTERR_CODE) begin
        st_d.frameErr = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign link.gtxClk   = st_q.gtxClk;
  assign link.txEn     = st_q.txEn;
  assign link.txEr     = st_q.txEr;
  assign link.txd      = st_q.txd;
  assign macRxValid    = st_q.rxValid;
  assign macRxData     = st_q.rxData;
  assign macRxFrameErr = st_q.frameErr;
  assign macRxExtend   = st_q.rxExtend;
  assign macRxEnd      = st_q.rxEnd;
  assign macCrs        = st_q.crsS2;
  assign macCol        = st_q.colS2;

endmodule : gmii_rs_end

// ==== verif/gmii_rs_phy_signaling_chk.sv ====
`include "gmii_regs.svh"

module gmii_rs_phy_signaling_chk (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       gtxClk,
  input wire logic       txEn,
  input wire logic       txEr,
  input wire logic [7:0] txd,
  input wire logic       rxClk,
  input wire logic       rxDv,
  input wire logic       rxEr,
  input wire logic [7:0] rxd,
  input wire logic       crs,
  input wire logic       col
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int MaxPhase = `GMII_MAX_PHASE_CYC;
  logic [7:0] phaseLen_q;
  logic       txAct_q;
  logic       rxAct_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  sequence rxHighHold;
    rxClk [*3];
  endsequence
  sequence rxLowHold;
    !rxClk [*3];
  endsequence

  // Extension legality needs the previous octet
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      phaseLen_q <= 8'h00;
      txAct_q    <= 1'b0;
      rxAct_q    <= 1'b0;
    end else begin
      phaseLen_q <= $changed(rxClk) ? 8'h01 : phaseLen_q + 8'h01;
      txAct_q    <= $rose(gtxClk) ? txEn | txEr : txAct_q;
      rxAct_q    <= $rose(rxClk) ? rxDv | rxEr : rxAct_q;
    end
  end

  chk_tx_sync: assert property ($changed({txEn, txEr, txd}) |-> $rose(gtxClk))
    else $error("transmit lines moved off clock");
  chk_rx_sync: assert property ($changed({rxDv, rxEr, rxd}) |-> $rose(rxClk))
    else $error("receive lines moved off clock");
  chk_rx_high_min: assert property ($rose(rxClk) |=> rxHighHold)
    else $error("receive clock high too short");
  chk_rx_low_min: assert property ($fell(rxClk) |=> rxLowHold)
    else $error("receive clock low too short");
  chk_rx_max_phase: assert property (phaseLen_q <= MaxPhase)
    else $error("receive clock phase too long");
  chk_tx_ext_order: assert property ($rose(gtxClk) && !txEn && txEr |-> txAct_q)
    else $error("transmit extension not after frame");
  chk_rx_ext_order: assert property ($rose(rxClk) && !rxDv && rxEr |-> rxAct_q)
    else $error("receive extension not after frame");
  chk_col_crs: assert property (col |-> crs)
    else $error("collision without carrier sense");
  chk_crs_rx: assert property ($rose(rxDv) |-> ##[0:3] crs)
    else $error("no carrier sense on receive");
endmodule : gmii_rs_phy_signaling_chk

// ==== verif/test_gmii_rs_phy_signaling.sv ====
`include "gmii_regs.svh"

module test_gmii_rs_phy_signaling;
  timeunit 1ns;
  timeprecision 1ps;

  logic           mclk = 1'b0, reset = 1'b1, recClk = 1'b0, sigLost = 1'b0, repeaterMode = 1'b0;
  logic           macTxEn = 1'b0, macTxErr = 1'b0, macTxExtend = 1'b0, macTxExtErr = 1'b0, loopbackEn = 1'b0;
  logic [7:0]     macTxData = 8'h00;
  logic [7:0]     medRxData = 8'h00;
  gmii_pkg::sym_t medRxSym = gmii_pkg::SYM_IDLE;
  gmii_pkg::sym_t medTxSym;
  gmii_pkg::sym_t s;
  logic [7:0]     medTxData;
  logic [7:0]     macRxData;
  logic           medRxTake, medTxStrobe, macTxTake, macRxValid, macRxFrameErr, macRxExtend, macCrs, macCol;
  logic           macRxEnd;
  logic           crsSeen = 1'b0, colSeen = 1'b0, rxFe = 1'b0;
  logic [15:0]    seed = 16'hf7fa;
  int             errTotal = 0, totalChecks = 0, txPrev = 0, rxAct = 0, rxDvPrev = 0, endExp = 0, e;
  int             txReq[$], rxReq[$], txExp[$], rxExp[$];

  gmii_if link ();
  gmii_phy_end i_gmii_phy_end (
    .mclk, .reset, .link, .recClk, .sigLost, .loopbackEn, .repeaterMode,
    .medRxSym, .medRxData, .medRxTake, .medTxSym, .medTxData, .medTxStrobe
  );
  gmii_rs_end i_gmii_rs_end (
    .mclk, .reset, .link, .macTxEn, .macTxErr, .macTxData, .macTxExtend, .macTxExtErr, .macTxTake,
    .macRxValid, .macRxData, .macRxFrameErr, .macRxExtend, .macRxEnd, .macCrs, .macCol
  );
  gmii_rs_phy_signaling_chk i_chk (
    .mclk, .reset, .gtxClk(link.gtxClk), .txEn(link.txEn), .txEr(link.txEr), .txd(link.txd),
    .rxClk(link.rxClk), .rxDv(link.rxDv), .rxEr(link.rxEr), .rxd(link.rxd), .crs(link.crs), .col(link.col)
  );

  always #5 mclk = ~mclk;
  always #62.5 recClk = ~recClk;

  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction : rnd

  task automatic check(input logic ok, input string msg);
    totalChecks++;
    if (ok !== 1'b1) begin
      errTotal++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check

  task automatic stop_test();
    if (errTotal == 0 && totalChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // Shared by the medium path and the looped transmit path
  task automatic rx_model(input gmii_pkg::sym_t sym, input logic [7:0] d);
    if (sym inside {gmii_pkg::SYM_DATA, gmii_pkg::SYM_ERROR}) begin
      rxFe = rxDvPrev ? rxFe : 1'b0;
      rxFe = sym == gmii_pkg::SYM_ERROR ? 1'b1 : rxFe;
      rxExp.push_back({1'b0, rxFe, d});
      rxDvPrev = 1;
      rxAct = 1;
    end else begin
      endExp += rxDvPrev;
      rxDvPrev = 0;
      if (sym != gmii_pkg::SYM_IDLE && rxAct) begin
        rxFe = sym == gmii_pkg::SYM_EXTERR ? 1'b1 : rxFe;
        rxExp.push_back({1'b1, rxFe, 8'h00});
      end else begin
        rxAct = 0;
      end
    end
  endtask : rx_model

  task automatic send_frame(input logic withTx, input logic withRx);
    for (int i = 0; i < 6; i++) begin
      if (withTx) txReq.push_back({i == 3 ? 4'h3 : 4'h1, rnd()});
      if (withRx) rxReq.push_back({i == 2 ? gmii_pkg::SYM_ERROR : gmii_pkg::SYM_DATA, rnd()});
    end
    if (withTx) txReq = {txReq, 12'h400, 12'h400, 12'hc00, 12'h000, 12'h400, 12'h000};
    if (withRx) rxReq = {rxReq, 11'h200, 11'h700, 11'h000, 11'h200, {3'h1, rnd()}, 11'h000};
  endtask : send_frame

  task automatic settle();
    int n = 0;
    while ((txReq.size() || rxReq.size() || rxExp.size()) && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    check(n < 3000, "stream stuck");
    repeat (40) @(negedge mclk);
  endtask : settle

  always @(negedge mclk) begin
    if (macCrs === 1'b1) crsSeen = 1'b1;
    if (macCol === 1'b1) colSeen = 1'b1;
    // transmit model; the octet set now is taken at the next edge
    if (macTxTake === 1'b1) begin
      e = txReq.size() ? txReq.pop_front() : 0;
      {macTxExtErr, macTxExtend, macTxErr, macTxEn, macTxData} = e[11:0];
      if (macTxEn) begin
        s = macTxErr ? gmii_pkg::SYM_ERROR : gmii_pkg::SYM_DATA;
        txExp.push_back({!macTxErr, s, macTxData});
        txPrev = 1;
      end else if (macTxExtend && txPrev != 0) begin
        s = macTxExtErr ? gmii_pkg::SYM_EXTERR : gmii_pkg::SYM_EXTEND;
        s = txPrev == 1 ? gmii_pkg::SYM_EOP : s;
        txExp.push_back({1'b0, s, 8'h00});
        txPrev = 2;
      end else begin
        s = gmii_pkg::SYM_IDLE;
        txExp.push_back(12'h800);
        txPrev = 0;
      end
      if (loopbackEn) rx_model(s, macTxData);
    end
    if (medTxStrobe === 1'b1) begin
      e = txExp.size() ? txExp.pop_front() : 12'h800;
      check(medTxSym === e[10:8] && (!e[11] || medTxData === e[7:0]), "transmit symbol");
    end
    if (medRxTake === 1'b1) begin
      e = rxReq.size() ? rxReq.pop_front() : 0;
      medRxSym = gmii_pkg::sym_t'(e[10:8]);
      medRxData = e[7:0];
      rx_model(medRxSym, medRxData);
    end
    if (macRxEnd === 1'b1) begin
      check(endExp > 0, "frame end");
      endExp--;
    end
    if (macRxValid === 1'b1 || macRxExtend === 1'b1) begin
      e = rxExp.size() ? rxExp.pop_front() : 12'hfff;
      check({macRxExtend, macRxFrameErr} === e[9:8] && (e[9] || macRxData === e[7:0]), "receive octet");
    end
  end

  initial begin
    #100us;
    errTotal++;
    $display("[FAIL] %0t watchdog", $time);
    stop_test();
  end

  // Phases: station tx, repeater tx, collision, repeater rx on local clock, loopback
  initial begin
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    for (int p = 0; p < 5; p++) begin
      repeaterMode = p[0];
      sigLost = p >= 3;
      loopbackEn = p == 4;
      crsSeen = 1'b0;
      colSeen = 1'b0;
      send_frame(p != 3, p inside {2, 3});
      settle();
      check(endExp == 0, "frame end count");
      check(crsSeen === (p != 1), "carrier sense");
      check(colSeen === (p == 2), "collision");
    end
    stop_test();
  end
endmodule : test_gmii_rs_phy_signaling
